// ===== verilog/cpu_status_panel.sv
/*
 * cpu front-panel lamp driver, run-lamp blink codes, slide switch and
 * rotary switch decoding, with an avalon-mm register slave.
 * assumes switch and traffic inputs are asynchronous and need
 * synchronising; timing counts are top-level parameters.
 */
// Summary of operation
// (R01) ready lamp lights only after software reports diagnostics passed.
// (R02) run lamp lit while running; also carries blink error codes.
// (R03) serial activity lamp lights while serial traffic is seen.
// (R04) network activity lamp lights while network traffic is seen.
// (R05) memory-protect lamp lights while writes are blocked by switch.
// (R06) battery lamp lights when battery reported needing replacement.
// (R07) separate error lamps for network channel a and channel b.
// (R08) codes 80B, 80C, 82E blink twice per group.
// (R09) bus faults 769, 72A-730 blink three times per group.
// (R10) communication faults 604-631 blink four times per group.
// (R11) five blinks ram address or cpu, six ram data, seven executive.
// (R12) codes 8001 to 8003 blink eight times per group.
// (R13) protect on in top switch position, off middle and bottom.
// (R14) ascii or rtu position puts serial port in bridge mode.
// (R15) top position forces ascii 2400 even 7 data 1 stop.
// (R16) middle position forces rtu 9600 even 8 data 1 stop.
// (R17) fixed modes take slave address from rotary switches.
// (R18) bottom position takes software baud index of sixteen values.
// (R19) software parity, data bits, stop bits, address 1 to 247.
// (R20) rotary switches set network node and serial addresses.
// (R21) address is ten times tens digit plus ones digit.
// (R22) only switch addresses 1 to 64 are valid.
// (R23) invalid switch address holds network lamp steadily on.
// (R24) blink groups are separated by a longer off gap.
// (R25) one pending code shown at a time, fixed priority.
`timescale 1ns/100ps
module cpu_status_panel
   import panel_pkg::*;
#(
   parameter int BLINK_ON  = panel_pkg::BLINK_ON_CYC,
   parameter int BLINK_OFF = panel_pkg::BLINK_OFF_CYC,
   parameter int GROUP_GAP = panel_pkg::GROUP_GAP_CYC,
   parameter int ACT_HOLD  = panel_pkg::ACT_HOLD_CYC
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   // front and rear switches
   input  wire logic [1:0]  protect_switch,
   input  wire logic [1:0]  mode_switch,
   input  wire logic [3:0]  address_tens_switch,
   input  wire logic [3:0]  address_ones_switch,
   // traffic and channel errors
   input  wire logic        serial_traffic,
   input  wire logic        network_traffic,
   input  wire logic        chan_a_error,
   input  wire logic        chan_b_error,
   // lamps
   output logic             lamp_ready,
   output logic             lamp_run,
   output logic             lamp_serial,
   output logic             lamp_network,
   output logic             lamp_mem_protect,
   output logic             lamp_battery,
   output logic             lamp_error_a,
   output logic             lamp_error_b,
   // serial port configuration
   output logic [1:0]       ser_mode,
   output logic             ser_bridge,
   output logic [3:0]       ser_baud_index,
   output logic             ser_parity_en,
   output logic             ser_parity_odd,
   output logic             ser_data8,
   output logic             ser_stop2,
   output logic [7:0]       ser_address,
   output logic [6:0]       node_address,
   output logic             node_address_valid,
   output logic             write_protect
);
   import panel_pkg::*;

   // ******************************************************************
   // input synchronisers
   // ******************************************************************
   localparam int SYNC_W = 20;
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   wire  [SYNC_W-1:0] raw_in = {protect_switch, mode_switch, address_tens_switch, address_ones_switch,
                                serial_traffic, network_traffic, chan_a_error, chan_b_error,
                                4'h0};

   // two flops on every pin input
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   wire [1:0] prot_s  = sync2_reg[19:18];
   wire [1:0] mode_s  = sync2_reg[17:16];
   wire [3:0] tens_s  = sync2_reg[15:12];
   wire [3:0] ones_s  = sync2_reg[11:8];
   wire       ser_t_s = sync2_reg[7];
   wire       net_t_s = sync2_reg[6];
   wire       err_a_s = sync2_reg[5];
   wire       err_b_s = sync2_reg[4];

   // ******************************************************************
   // registers
   // ******************************************************************
   logic [3:0]  control_reg;
   logic [15:0] sercfg_reg;
   logic [6:0]  class_reg;         // pending blink classes, bit0 = 2 blinks
   logic [15:0] errcode_reg;       // last raised code

   // bus decode
   wire sel_status  = (avs_address == OFF_STATUS);
   wire sel_control = (avs_address == OFF_CONTROL);
   wire sel_sercfg  = (avs_address == OFF_SERCFG);
   wire sel_errcode = (avs_address == OFF_ERRCODE);
   wire mapped      = sel_status | sel_control | sel_sercfg | sel_errcode;
   wire wr_ctl      = avs_write & sel_control & avs_byteenable[0];
   wire wr_cfg      = avs_write & sel_sercfg;
   wire wr_err      = avs_write & sel_errcode;

   // code to blink-count classifier
   function automatic logic [6:0] classify(input logic [15:0] code);
      logic [6:0] c;
      c = 7'h00;
      if (code == 16'h080B || code == 16'h080C || code == 16'h082E)
         c[0] = 1'b1; // [R08]
      if (code == 16'h0769 || (code >= 16'h072A && code <= 16'h0730))
         c[1] = 1'b1; // [R09]
      if (code >= 16'h0604 && code <= 16'h0631)
         c[2] = 1'b1; // [R10]
      if (code == 16'h0503 || code == 16'h052D)
         c[3] = 1'b1; // [R11]
      if (code == 16'h0402)
         c[4] = 1'b1; // [R11]
      if (code == 16'h0300 || code == 16'h0301)
         c[5] = 1'b1; // [R11]
      if (code >= 16'h8001 && code <= 16'h8003)
         c[6] = 1'b1; // [R12]
      return c;
   endfunction : classify

   // writing a code raises its class; writing bit 31 clears all classes
   wire [6:0] new_class  = wr_err ? classify(avs_writedata[15:0]) : 7'h00;
   wire       clr_class  = wr_err & avs_writedata[31];
   wire [6:0] class_next = (clr_class ? 7'h00 : class_reg) | new_class;

   // register writes; set wins over clear on the class bits
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         control_reg <= CONTROL_RESET[3:0];
         sercfg_reg  <= SERCFG_RESET;
         class_reg   <= 7'h00;
         errcode_reg <= 16'h0000;
      end else begin
         if (wr_ctl)
            control_reg <= avs_writedata[3:0];
         if (wr_cfg && mode_s[1]) begin // [R15] [R16]
            if (avs_byteenable[0])
               sercfg_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1] && avs_writedata[15:8] != 8'h00
                && avs_writedata[15:8] <= ADDR_MAX_SER)
               sercfg_reg[15:8] <= avs_writedata[15:8]; // [R19]
         end
         class_reg <= class_next;
         if (wr_err && !avs_writedata[31])
            errcode_reg <= avs_writedata[15:0];
      end
   end

   // ******************************************************************
   // rotary switch address
   // ******************************************************************
   wire [6:0] sw_addr  = 7'(tens_s) * 7'h0A + 7'(ones_s); // [R21]
   wire       sw_valid = (sw_addr != 7'h00) && (sw_addr <= ADDR_MAX_SW[6:0])
                         && (ones_s <= 4'h9) && (tens_s <= 4'h9); // [R22]

   // ******************************************************************
   // slide switch decode
   // ******************************************************************
   wire       mode_ascii = (mode_s == POS_TOP);
   wire       mode_rtu   = (mode_s == POS_MIDDLE);
   wire       prot_on    = (prot_s == POS_TOP); // [R13]

   wire [1:0] mode_w    = mode_ascii ? MODE_ASCII : mode_rtu ? MODE_RTU : MODE_SOFT;
   wire [3:0] baud_w    = mode_ascii ? BAUD_2400 : mode_rtu ? BAUD_9600
                          : sercfg_reg[CFG_BAUD_LSB +: 4]; // [R15] [R16] [R18]
   wire       par_en_w  = (mode_ascii | mode_rtu) ? 1'b1 : sercfg_reg[CFG_PAR_EN];
   wire       par_odd_w = (mode_ascii | mode_rtu) ? 1'b0 : sercfg_reg[CFG_PAR_ODD];
   wire       data8_w   = mode_ascii ? 1'b0 : mode_rtu ? 1'b1 : sercfg_reg[CFG_DATA8];
   wire       stop2_w   = (mode_ascii | mode_rtu) ? 1'b0 : sercfg_reg[CFG_STOP2]; // [R19]
   wire [7:0] addr_w    = (mode_ascii | mode_rtu) ? {1'b0, sw_addr}
                          : sercfg_reg[CFG_ADDR_LSB +: 8]; // [R17] [R20]

   // ******************************************************************
   // activity stretchers
   // ******************************************************************
   logic [22:0] ser_hold_reg;
   logic [22:0] net_hold_reg;
   wire  [22:0] hold_load = 23'(ACT_HOLD);

   // keep activity lamps lit briefly after each traffic sample
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ser_hold_reg <= 23'h000000;
         net_hold_reg <= 23'h000000;
      end else begin
         ser_hold_reg <= ser_t_s ? hold_load : (ser_hold_reg != 0 ? ser_hold_reg - 23'h1 : 23'h0); // [R03]
         net_hold_reg <= net_t_s ? hold_load : (net_hold_reg != 0 ? net_hold_reg - 23'h1 : 23'h0); // [R04]
      end
   end

   // ******************************************************************
   // run-lamp blink sequencer
   // ******************************************************************
   typedef enum logic [1:0] {
      BL_IDLE = 2'b00,
      BL_ON   = 2'b01,
      BL_OFF  = 2'b10,
      BL_GAP  = 2'b11
   } blink_state_t;

   blink_state_t blink_reg;
   blink_state_t blink_next;
   logic [27:0]  timer_reg;
   logic [3:0]   left_reg;
   logic [3:0]   left_next;
   logic [27:0]  timer_next;

   // highest pending class wins
   function automatic logic [3:0] pick(input logic [6:0] c);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < NUM_CLASSES; i++)
         if (c[i])
            n = 4'(i) + BLINK_BASE;
      return n;
   endfunction : pick

   wire [3:0] pick_n  = pick(class_reg); // [R25]
   wire       tmr_end = (timer_reg == 28'h0);

   // sequencer next state
   always_comb begin
      blink_next = blink_reg;
      left_next  = left_reg;
      timer_next = tmr_end ? 28'h0 : timer_reg - 28'h1;
      unique case (blink_reg)
         BL_IDLE: begin
            if (pick_n != 4'h0) begin
               blink_next = BL_ON;
               left_next  = pick_n;
               timer_next = 28'(BLINK_ON - 1);
            end
         end
         BL_ON: begin
            if (tmr_end) begin
               left_next = left_reg - 4'h1;
               if (left_reg == 4'h1) begin
                  blink_next = BL_GAP;
                  timer_next = 28'(GROUP_GAP - 1); // [R24]
               end else begin
                  blink_next = BL_OFF;
                  timer_next = 28'(BLINK_OFF - 1);
               end
            end
         end
         BL_OFF: begin
            if (tmr_end) begin
               blink_next = BL_ON;
               timer_next = 28'(BLINK_ON - 1);
            end
         end
         BL_GAP: begin
            if (tmr_end)
               blink_next = BL_IDLE; // re-pick priority each group
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blink_reg <= BL_IDLE;
         timer_reg <= 28'h0;
         left_reg  <= 4'h0;
      end else begin
         blink_reg <= blink_next;
         timer_reg <= timer_next;
         left_reg  <= left_next;
      end
   end

   wire codes_pending = (class_reg != 7'h00) || (blink_reg != BL_IDLE);
   wire run_w = control_reg[CTL_KERNEL] ? 1'b1
                : codes_pending ? (blink_reg == BL_ON) // [R08] [R09] [R10] [R11] [R12]
                : control_reg[CTL_RUNNING]; // [R02]

   // ******************************************************************
   // lamp and configuration output flops
   // ******************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lamp_ready <= 1'b0;
         lamp_run <= 1'b0;
         lamp_serial <= 1'b0;
         lamp_network <= 1'b0;
         lamp_mem_protect <= 1'b0;
         lamp_battery <= 1'b0;
         lamp_error_a <= 1'b0;
         lamp_error_b <= 1'b0;
         ser_mode <= MODE_SOFT;
         ser_bridge <= 1'b0;
         ser_baud_index <= 4'h0;
         ser_parity_en <= 1'b0;
         ser_parity_odd <= 1'b0;
         ser_data8 <= 1'b0;
         ser_stop2 <= 1'b0;
         ser_address <= 8'h00;
         node_address <= 7'h00;
         node_address_valid <= 1'b0;
         write_protect <= 1'b0;
      end else begin
         lamp_ready <= control_reg[CTL_DIAG_OK]; // [R01]
         lamp_run <= run_w;
         lamp_serial <= (ser_hold_reg != 0); // [R03]
         lamp_network <= !sw_valid || (net_hold_reg != 0); // [R04] [R23]
         lamp_mem_protect <= prot_on; // [R05]
         lamp_battery <= control_reg[CTL_BAT_LOW]; // [R06]
         lamp_error_a <= err_a_s; // [R07]
         lamp_error_b <= err_b_s; // [R07]
         ser_mode <= mode_w;
         ser_bridge <= mode_ascii | mode_rtu; // [R14]
         ser_baud_index <= baud_w;
         ser_parity_en <= par_en_w;
         ser_parity_odd <= par_odd_w;
         ser_data8 <= data8_w;
         ser_stop2 <= stop2_w;
         ser_address <= addr_w;
         node_address <= sw_addr; // [R20]
         node_address_valid <= sw_valid;
         write_protect <= prot_on; // [R13]
      end
   end

   // ******************************************************************
   // bus read path: one-wait-cycle read answers, registered read data
   // ******************************************************************
   wire [31:0] status_w = {8'h00, 1'b0, sw_addr, 2'b00, mode_s, prot_s,
                           6'h00, sw_valid, lamp_run, (blink_reg != BL_IDLE), 1'b0};
   wire [31:0] rd_mux = sel_status  ? status_w
                      : sel_control ? {28'h0, control_reg}
                      : sel_sercfg  ? {16'h0, sercfg_reg}
                      : sel_errcode ? {9'h0, class_reg, errcode_reg}
                      : 32'h0;

   logic rd_done_reg;

   // reads take one wait cycle so data comes from a flop
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0;
         avs_response <= 2'b00;
         rd_done_reg  <= 1'b0;
      end else begin
         rd_done_reg  <= avs_read & ~rd_done_reg;
         if (avs_read & ~rd_done_reg) begin
            avs_readdata <= rd_mux;
            avs_response <= mapped ? 2'b00 : 2'b11;
         end
      end
   end

   assign avs_waitrequest = avs_read & ~rd_done_reg;

endmodule : cpu_status_panel

// ===== verilog/panel_pkg.sv
/*
 * constants for the cpu front-panel status and port configuration block:
 * register map, field positions, reset values, blink timing, framing codes.
 * assumes a 100 MHz system clock and a 32-bit avalon-mm register bus.
 */
package panel_pkg;

   // ******************************************************************
   // register map (byte addresses)
   // ******************************************************************
   localparam logic [3:0] OFF_STATUS   = 4'h0;
   localparam logic [3:0] OFF_CONTROL  = 4'h4;
   localparam logic [3:0] OFF_SERCFG   = 4'h8;
   localparam logic [3:0] OFF_ERRCODE  = 4'hC;

   // ******************************************************************
   // control register fields
   // ******************************************************************
   localparam int CTL_DIAG_OK   = 0;
   localparam int CTL_RUNNING   = 1;
   localparam int CTL_BAT_LOW   = 2;
   localparam int CTL_KERNEL    = 3;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

   // ******************************************************************
   // serial config register fields (software mode)
   // ******************************************************************
   localparam int CFG_BAUD_LSB  = 0;   // 4 bits, baud index
   localparam int CFG_PAR_EN    = 4;
   localparam int CFG_PAR_ODD   = 5;
   localparam int CFG_DATA8     = 6;
   localparam int CFG_STOP2     = 7;
   localparam int CFG_ADDR_LSB  = 8;   // 8 bits, slave address
   localparam logic [15:0] SERCFG_RESET = 16'h0146;  // addr 1, baud index 6, 8 data

   // ******************************************************************
   // baud indices and address limits
   // ******************************************************************
   localparam logic [3:0] BAUD_2400 = 4'h5;
   localparam logic [3:0] BAUD_9600 = 4'h1;
   localparam logic [7:0] ADDR_MAX_SW  = 8'h40;  // 64
   localparam logic [7:0] ADDR_MAX_SER = 8'hF7;  // 247

   // ******************************************************************
   // switch positions and modes
   // ******************************************************************
   typedef enum logic [1:0] {
      POS_TOP    = 2'b00,
      POS_MIDDLE = 2'b01,
      POS_BOTTOM = 2'b10
   } switch_pos_t;

   typedef enum logic [1:0] {
      MODE_ASCII = 2'b00,
      MODE_RTU   = 2'b01,
      MODE_SOFT  = 2'b10
   } ser_mode_t;

   // ******************************************************************
   // blink and activity-hold timing
   // ******************************************************************
   localparam int CLK_HZ        = 100_000_000;
   localparam int BLINK_ON_MS   = 250;
   localparam int BLINK_OFF_MS  = 250;
   localparam int GROUP_GAP_MS  = 1500;
   localparam int BLINK_ON_CYC  = CLK_HZ / 1000 * BLINK_ON_MS;
   localparam int BLINK_OFF_CYC = CLK_HZ / 1000 * BLINK_OFF_MS;
   localparam int GROUP_GAP_CYC = CLK_HZ / 1000 * GROUP_GAP_MS;
   localparam int ACT_HOLD_MS   = 50;
   localparam int ACT_HOLD_CYC  = CLK_HZ / 1000 * ACT_HOLD_MS;

   // ******************************************************************
   // error classes (blink counts), higher count wins
   // ******************************************************************
   localparam int NUM_CLASSES = 7;   // 2 through 8 blinks
   localparam logic [3:0] BLINK_BASE = 4'h2;

endpackage : panel_pkg

// ===== verification/serial_panel_model.sv
/* panel device on the serial port: sends a traffic burst on request.
   assumes send is a one-clock pulse from the bench. */
`timescale 1ns/100ps
module serial_panel_model (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic send,
   output logic      serial_traffic
);
   logic [2:0] left_reg;
   // six-clock burst, line idles low between bursts
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) left_reg <= 3'h0;
      else if (send) left_reg <= 3'h6;
      else if (left_reg != 3'h0) left_reg <= left_reg - 3'h1;
   end
   assign serial_traffic = (left_reg != 3'h0);
endmodule : serial_panel_model

// ===== verification/cpu_status_panel_properties.sv
/* assertions for the panel block: switch decode, framing, lamps.
   assumes a bind to cpu_status_panel and async active-high reset. */
`timescale 1ns/100ps
module cpu_status_panel_properties
   import panel_pkg::*;
(
   // clock, reset and inputs
   input wire logic       sys_clk, sys_rst, chan_a_error,
   input wire logic [1:0] protect_switch,
   input wire logic [3:0] address_tens_switch, address_ones_switch,
   // outputs
   input wire logic       lamp_network, lamp_mem_protect, lamp_error_a, write_protect, node_address_valid,
   input wire logic       ser_bridge, ser_parity_en, ser_parity_odd, ser_data8, ser_stop2,
   input wire logic [1:0] ser_mode,
   input wire logic [3:0] ser_baud_index,
   input wire logic [7:0] ser_address,
   input wire logic [6:0] node_address
);
   logic [6:0] sw_sum;
   logic [3:0] frame;
   // ********
   // decode
   // ********
   assign sw_sum = address_tens_switch * 7'h0A + address_ones_switch;
   assign frame = {ser_parity_en, ser_parity_odd, ser_data8, ser_stop2};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // digits steady and decimal long enough to cross the synchronisers
   sequence s_digits;
      ($stable({address_tens_switch, address_ones_switch})
       && address_ones_switch < 4'hA && address_tens_switch < 4'hA) [*4];
   endsequence
   AST_PROT_SW: assert property ($stable(protect_switch) [*4] |-> write_protect == (protect_switch == POS_TOP))
      else $error("protect");
   AST_PROT_LAMP: assert property (lamp_mem_protect == write_protect)
      else $error("protect lamp");
   AST_BRIDGE: assert property (ser_bridge == (ser_mode != MODE_SOFT))
      else $error("bridge");
   AST_ASCII: assert property (ser_mode == MODE_ASCII |-> ser_baud_index == BAUD_2400 && frame == 4'h8)
      else $error("ascii");
   AST_RTU: assert property (ser_mode == MODE_RTU |-> ser_baud_index == BAUD_9600 && frame == 4'hA)
      else $error("rtu");
   AST_FIX_ADDR: assert property (ser_mode != MODE_SOFT && node_address_valid |-> ser_address == {1'b0, node_address})
      else $error("fixed addr");
   AST_SUM: assert property (s_digits |-> node_address == sw_sum)
      else $error("addr sum");
   AST_VALID: assert property (s_digits |-> node_address_valid == (sw_sum inside {[7'h01:7'h40]}))
      else $error("addr valid");
   AST_INVALID: assert property (!node_address_valid [*4] |-> lamp_network)
      else $error("bad addr lamp");
   AST_ERR_A: assert property ($stable(chan_a_error) [*4] |-> lamp_error_a == chan_a_error)
      else $error("error a lamp");
endmodule : cpu_status_panel_properties
bind cpu_status_panel cpu_status_panel_properties u_props (.*);

// ===== verification/cpu_status_panel_tb.sv
/* bench for the panel block: one avalon-mm master task, one task per test.
   assumes short blink and hold counts and the serial panel model. */
`timescale 1ns/100ps
module cpu_status_panel_tb;
   import panel_pkg::*;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, send = 1'b0;
   logic        network_traffic = 1'b0, chan_a_error = 1'b0, chan_b_error = 1'b0, run_on;
   logic [1:0]  protect_switch = 2'h2, mode_switch = 2'h2, avs_response, ser_mode;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF, address_tens_switch = 4'h1, address_ones_switch = 4'h1;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic        serial_traffic, avs_waitrequest, lamp_ready, lamp_run, lamp_serial, lamp_network, lamp_battery;
   logic        lamp_mem_protect, lamp_error_a, lamp_error_b, ser_bridge, ser_parity_en, ser_parity_odd;
   logic        ser_data8, ser_stop2, node_address_valid, write_protect;
   logic [3:0]  ser_baud_index;
   logic [7:0]  ser_address, d;
   logic [6:0]  node_address;
   logic [15:0] port_cfg;
   int          n_errors = 0, n_tests = 0, cycles = 0, n;
   assign run_on = (lamp_run === 1'b1);
   assign port_cfg = {ser_baud_index, ser_parity_en, ser_parity_odd, ser_data8, ser_stop2, ser_address};
   cpu_status_panel #(.BLINK_ON(4), .BLINK_OFF(4), .GROUP_GAP(16), .ACT_HOLD(8)) u_dut (.*);
   serial_panel_model u_model (.sys_clk, .sys_rst, .send, .serial_traffic);
   // clock and run ceiling
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   // ********
   // helpers
   // ********
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk);
   endtask : settle
   // wait out a gap, then count run-lamp pulses up to the next gap
   task automatic count_group;
      int low;
      low = 0;
      n = 0;
      while (low < 10) begin
         @(posedge sys_clk);
         low = run_on ? 0 : low + 1;
      end
      while (n == 0 || low < 10) begin
         @(posedge sys_clk);
         if (run_on && low > 0) n++;
         low = run_on ? 0 : low + 1;
      end
   endtask : count_group
   task automatic t_blink;
      logic [15:0] codes [7] = '{16'h080B, 16'h0769, 16'h0604, 16'h0503, 16'h0402, 16'h0300, 16'h8001};
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, OFF_ERRCODE, 32'h8000_0000);
         bus(1'b1, OFF_ERRCODE, {16'h0000, codes[i]});
         count_group();
         check("blinks", n, i + 2);
      end
      bus(1'b1, OFF_ERRCODE, 32'h0000_0503);
      count_group();
      check("priority blinks", n, 8);
      bus(1'b1, OFF_ERRCODE, 32'h8000_0000);
      settle(20);
      $display("test blink done");
   endtask : t_blink
   task automatic t_ctrl;
      bus(1'b1, OFF_CONTROL, 32'h0000_000D);
      settle(2);
      check("ready run battery", {lamp_ready, lamp_run, lamp_battery}, 3'h7);
      bus(1'b0, OFF_CONTROL, 32'h0);
      check("control", rd, 32'h0000_000D);
      bus(1'b1, OFF_CONTROL, 32'h0);
      settle(2);
      check("lamps off", {lamp_ready, lamp_run, lamp_battery}, 3'h0);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped read", {rd[29:0], avs_response}, 32'h3);
      $display("test control done");
   endtask : t_ctrl
   task automatic t_serial;
      logic [15:0] fixed [2] = '{16'h580B, 16'h1A0B};
      for (int p = 0; p < 3; p++) begin
         protect_switch <= 2'(p);
         mode_switch <= 2'(p);
         settle(5);
         check("protect", {write_protect, lamp_mem_protect}, {2{p == 0}});
         check("mode bridge", {ser_mode, ser_bridge}, {2'(p), p != 2});
         if (p < 2) check("fixed port", port_cfg, fixed[p]);
      end
      bus(1'b1, OFF_SERCFG, 32'h0000_F7BF);
      settle(2);
      check("soft port", port_cfg, 16'hFDF7);
      bus(1'b1, OFF_SERCFG, 32'h0000_0046);
      bus(1'b1, OFF_SERCFG, 32'h0000_F846);
      settle(2);
      check("soft address kept", port_cfg, 16'h62F7);
      mode_switch <= 2'h0;
      settle(5);
      bus(1'b1, OFF_SERCFG, 32'h0000_0203);
      bus(1'b0, OFF_SERCFG, 32'h0);
      check("locked config", {rd[15:0], port_cfg}, {16'hF746, 16'h580B});
      $display("test serial done");
   endtask : t_serial
   task automatic t_addr;
      logic [7:0] digits [5] = '{8'h64, 8'h65, 8'h00, 8'h09, 8'h11};
      for (int i = 0; i < 5; i++) begin
         d = digits[i];
         {address_tens_switch, address_ones_switch} <= d;
         settle(5);
         n = d[7:4] * 10 + d[3:0];
         check("address", {node_address, node_address_valid, lamp_network}, {7'(n), n inside {[1:64]}, !(n inside {[1:64]})});
      end
      $display("test address done");
   endtask : t_addr
   task automatic t_traffic;
      send <= 1'b1;
      network_traffic <= 1'b1;
      chan_a_error <= 1'b1;
      @(posedge sys_clk);
      send <= 1'b0;
      settle(5);
      check("lamps busy", {lamp_serial, lamp_network, lamp_error_a, lamp_error_b}, 4'hE);
      network_traffic <= 1'b0;
      chan_a_error <= 1'b0;
      chan_b_error <= 1'b1;
      settle(30);
      check("lamps idle", {lamp_serial, lamp_network, lamp_error_a, lamp_error_b}, 4'h1);
      $display("test traffic done");
   endtask : t_traffic
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   // reset, then the tests in turn
   initial begin
      repeat (12) @(posedge sys_clk);
      check("reset ready", lamp_ready, 1'b0);
      sys_rst <= 1'b0;
      t_blink();
      t_ctrl();
      t_serial();
      t_addr();
      t_traffic();
      complete_run();
   end
endmodule : cpu_status_panel_tb
